// ==== common/afd_defines.vh ====
// Constants for the fast-detect, overrange and power-down block.
// Assumes inclusion by bare name from the core design files.
`ifndef AFD_DEFINES_VH
`define AFD_DEFINES_VH

// Register offsets on the configuration port.
`define AFD_OFS_PD_CTRL_A 12'h03F
`define AFD_OFS_PD_CTRL_B 12'h040
`define AFD_OFS_UPPER_P0 12'h247
`define AFD_OFS_UPPER_P1 12'h248
`define AFD_OFS_LOWER_P0 12'h249
`define AFD_OFS_LOWER_P1 12'h24A
`define AFD_OFS_DWELL_P0 12'h24B
`define AFD_OFS_DWELL_P1 12'h24C
`define AFD_OFS_OVR_CLEAR 12'h562
`define AFD_OFS_OVR_STICKY 12'h563
`define AFD_OFS_FILL_SEL 12'h571

// Reset values of the writable registers.
`define AFD_RST_PD_CTRL_A 8'h00
`define AFD_RST_PD_CTRL_B 8'h00
`define AFD_RST_UPPER_P0 8'hFF
`define AFD_RST_UPPER_P1 8'h1F
`define AFD_RST_LOWER_P0 8'h00
`define AFD_RST_LOWER_P1 8'h00
`define AFD_RST_DWELL_P0 8'h01
`define AFD_RST_DWELL_P1 8'h00
`define AFD_RST_OVR_CLEAR 8'h00
`define AFD_RST_FILL_SEL 8'h00

// Field positions.
`define AFD_THR_HI_MSB 4
`define AFD_FILL_K_BIT 7
`define AFD_MODE_MSB 1

// Software power mode codes in power_down_control_a bits 1:0.
`define AFD_SW_NORMAL 2'h0
`define AFD_SW_STANDBY 2'h2
`define AFD_SW_PDOWN 2'h3

// Pin function codes in power_down_control_b bits 1:0.
`define AFD_PIN_PDOWN 2'h0
`define AFD_PIN_STANDBY 2'h1

// Value answered for an unmapped address.
`define AFD_UNMAPPED 8'h00

`endif

// ==== core/afd_fd_chan.v ====
// One channel of fast threshold detection with dwell hysteresis.
// Assumes one sample per clock and a 13-bit magnitude already formed.
`timescale 1ns/1ps
module afd_fd_chan #(
   parameter MAG_W = 13,
   parameter DWELL_W = 16
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [MAG_W-1:0] mag_i,
   input wire [MAG_W-1:0] upper_i,
   input wire [MAG_W-1:0] lower_i,
   input wire [DWELL_W-1:0] dwell_i,
   output wire flag_o
);
   // Flag register driving the pin and the count of cycles below lower.
   reg flag_q;
   reg [DWELL_W-1:0] cnt_q;

   assign flag_o = flag_q;

   // Set at once above upper; clear only after more than dwell cycles below lower.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
         cnt_q <= {DWELL_W{1'b0}};
      end else if (mag_i > upper_i) begin
         // Upper crossing wins and sets the flag next edge.
         flag_q <= 1'b1;
         cnt_q <= {DWELL_W{1'b0}};
      end else if (mag_i < lower_i) begin
         // Count dwell cycles; clear once the count has reached dwell.
         if (cnt_q >= dwell_i) begin
            flag_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + {{(DWELL_W-1){1'b0}}, 1'b1};
         end
      end else begin
         // Back at or above lower: the dwell restarts.
         cnt_q <= {DWELL_W{1'b0}};
      end
   end
endmodule

// ==== core/afd_ovr_sticky.v ====
// Sticky overrange status, one bit per virtual converter.
// Assumes the clear register is written by software as a one then a zero.
`timescale 1ns/1ps
module afd_ovr_sticky #(
   parameter NVC = 8
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [NVC-1:0] ovr_i,
   input wire [NVC-1:0] clear_reg_i,
   output wire [NVC-1:0] sticky_o
);
   // Previous clear register value, to see the one-to-zero step.
   reg [NVC-1:0] clr_prev_q;
   reg [NVC-1:0] sticky_q;
   // A bit is cleared when its clear bit goes from one back to zero.
   wire [NVC-1:0] clr_pulse = clr_prev_q & ~clear_reg_i;

   assign sticky_o = sticky_q;

   // Set has priority over clear so a same-cycle event is kept.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         clr_prev_q <= {NVC{1'b0}};
         sticky_q <= {NVC{1'b0}};
      end else begin
         clr_prev_q <= clear_reg_i;
         sticky_q <= (sticky_q & ~clr_pulse) | ovr_i;
      end
   end
endmodule

// ==== core/afd_top.v ====
// Top of the dual-channel fast-detect, overrange and power-down block.
// Assumes samples and overrange flags arrive one per clock on clk_sys_i,
// and that configuration reaches it over a plain register port.
//
// How it works
// - Two channels, separate comparators and flag pins.
// - Flag sets at once above upper threshold.
// - Flag clears after dwell below lower threshold.
// - Upper threshold from two registers, output magnitude.
// - Flag asserts within twenty-eight clocks.
// - Lower threshold is 13 bits, two registers.
// - Dwell one to 65535 clocks, two registers.
// - Overrange bit carried in-band, sample-aligned.
// - Sticky overrange bit per virtual converter.
// - Clear by writing clear bit one, then zero.
// - Active-high pin, power-down default, halts link.
// - Power-down also selectable through two registers.
// - Standby keeps link running, sends zero samples.
// - Register bit selects zeros or K characters.
// - Eight virtual converters carry sticky status.
`timescale 1ns/1ps
`include "afd_defines.vh"
module afd_top #(
   parameter SMP_W = 14,
   parameter MAG_W = 13,
   parameter DWELL_W = 16,
   parameter NVC = 8
) (
   input wire clk_sys_i,
   input wire rst_i,
   // Converter samples, two's complement, one per clock.
   input wire [SMP_W-1:0] sample_a_i,
   input wire [SMP_W-1:0] sample_b_i,
   // Converter input overrange flags, aligned with the samples.
   input wire ovr_a_i,
   input wire ovr_b_i,
   // Overrange flags of the eight virtual converters.
   input wire [NVC-1:0] vc_ovr_i,
   // High when control bits per sample are configured on the link.
   input wire ctrl_bits_en_i,
   // Power-down or standby pin, active high.
   input wire powerdown_standby_pin_i,
   // Configuration register port.
   input wire [11:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [7:0] reg_rdata_o,
   output wire reg_rvalid_o,
   // Fast-detect pins.
   output wire level_flag_chan_a_o,
   output wire level_flag_chan_b_o,
   // Link-facing sample streams with their in-band overrange bits.
   output wire [SMP_W-1:0] link_sample_a_o,
   output wire [SMP_W-1:0] link_sample_b_o,
   output wire link_ovr_a_o,
   output wire link_ovr_b_o,
   output wire link_is_k_o,
   output wire link_run_o,
   output wire powered_down_o
);
   // Magnitude of a signed sample, saturated to the magnitude width.
   function [MAG_W-1:0] mag_of;
      input [SMP_W-1:0] s;
      reg [SMP_W-1:0] a;
      begin
         a = s[SMP_W-1] ? (~s + {{(SMP_W-1){1'b0}}, 1'b1}) : s;
         if (a[SMP_W-1]) begin
            mag_of = {MAG_W{1'b1}};
         end else begin
            mag_of = a[MAG_W-1:0];
         end
      end
   endfunction

   // True when a register write targets the given offset.
   function hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // Configuration registers.
   reg [7:0] pd_ctrl_a_q; // Software power mode.
   reg [7:0] pd_ctrl_b_q; // Pin function select.
   reg [7:0] upper_p0_q; // Upper threshold low byte.
   reg [7:0] upper_p1_q; // Upper threshold high bits.
   reg [7:0] lower_p0_q; // Lower threshold low byte.
   reg [7:0] lower_p1_q; // Lower threshold high bits.
   reg [7:0] dwell_p0_q; // Dwell low byte.
   reg [7:0] dwell_p1_q; // Dwell high byte.
   reg [7:0] ovr_clear_q; // Sticky clear bits.
   reg [7:0] fill_sel_q; // Standby fill select.

   // Read answer registers.
   reg [7:0] rdata_q;
   reg rvalid_q;
   reg [7:0] rdata_d;

   // Magnitude stage registers, one per channel.
   reg [MAG_W-1:0] mag_a_q;
   reg [MAG_W-1:0] mag_b_q;

   // Link output registers.
   reg [SMP_W-1:0] link_a_q;
   reg [SMP_W-1:0] link_b_q;
   reg link_ovr_a_q;
   reg link_ovr_b_q;
   reg link_k_q;
   reg link_run_q;
   reg pd_q;

   // Thresholds and dwell assembled from their register pairs.
   wire [MAG_W-1:0] upper_thr;
   wire [MAG_W-1:0] lower_thr;
   wire [DWELL_W-1:0] dwell;
   wire [NVC-1:0] sticky;

   // Effective power state from pin and registers.
   wire sw_pd;
   wire sw_sb;
   wire pin_pd;
   wire pin_sb;
   wire pd_now;
   wire sb_now;

   // Upper threshold spans two registers.
   assign upper_thr = {upper_p1_q[`AFD_THR_HI_MSB:0], upper_p0_q};
   // Lower threshold is the same 13-bit split.
   assign lower_thr = {lower_p1_q[`AFD_THR_HI_MSB:0], lower_p0_q};
   // Dwell is a full 16-bit pair; software keeps it nonzero.
   assign dwell = {dwell_p1_q, dwell_p0_q};

   // Register-selected power-down or standby.
   assign sw_pd = (pd_ctrl_a_q[`AFD_MODE_MSB:0] == `AFD_SW_PDOWN);
   assign sw_sb = (pd_ctrl_a_q[`AFD_MODE_MSB:0] == `AFD_SW_STANDBY);
   // The pin is active high and means power-down by default.
   assign pin_pd = powerdown_standby_pin_i &
                   (pd_ctrl_b_q[`AFD_MODE_MSB:0] == `AFD_PIN_PDOWN);
   assign pin_sb = powerdown_standby_pin_i &
                   (pd_ctrl_b_q[`AFD_MODE_MSB:0] == `AFD_PIN_STANDBY);
   // Power-down has priority over standby.
   assign pd_now = sw_pd | pin_pd;
   assign sb_now = ~pd_now & (sw_sb | pin_sb);

   // Outputs come straight from flip-flops.
   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign link_sample_a_o = link_a_q;
   assign link_sample_b_o = link_b_q;
   assign link_ovr_a_o = link_ovr_a_q;
   assign link_ovr_b_o = link_ovr_b_q;
   assign link_is_k_o = link_k_q;
   assign link_run_o = link_run_q;
   assign powered_down_o = pd_q;

   // Register writes; the sticky status register is read only.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pd_ctrl_a_q <= `AFD_RST_PD_CTRL_A;
         pd_ctrl_b_q <= `AFD_RST_PD_CTRL_B;
         upper_p0_q <= `AFD_RST_UPPER_P0;
         upper_p1_q <= `AFD_RST_UPPER_P1;
         lower_p0_q <= `AFD_RST_LOWER_P0;
         lower_p1_q <= `AFD_RST_LOWER_P1;
         dwell_p0_q <= `AFD_RST_DWELL_P0;
         dwell_p1_q <= `AFD_RST_DWELL_P1;
         ovr_clear_q <= `AFD_RST_OVR_CLEAR;
         fill_sel_q <= `AFD_RST_FILL_SEL;
      end else if (reg_wr_i) begin
         // Each offset decodes to exactly one register.
         if (hit(reg_addr_i, `AFD_OFS_PD_CTRL_A)) begin
            pd_ctrl_a_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_PD_CTRL_B)) begin
            pd_ctrl_b_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_UPPER_P0)) begin
            upper_p0_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_UPPER_P1)) begin
            upper_p1_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_LOWER_P0)) begin
            lower_p0_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_LOWER_P1)) begin
            lower_p1_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_DWELL_P0)) begin
            dwell_p0_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_DWELL_P1)) begin
            dwell_p1_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_OVR_CLEAR)) begin
            ovr_clear_q <= reg_wdata_i;
         end
         if (hit(reg_addr_i, `AFD_OFS_FILL_SEL)) begin
            fill_sel_q <= reg_wdata_i;
         end
      end
   end

   // Read decode; unused threshold bits and unmapped offsets read zero.
   always @* begin
      rdata_d = `AFD_UNMAPPED;
      case (reg_addr_i)
         `AFD_OFS_PD_CTRL_A: rdata_d = pd_ctrl_a_q;
         `AFD_OFS_PD_CTRL_B: rdata_d = pd_ctrl_b_q;
         `AFD_OFS_UPPER_P0: rdata_d = upper_p0_q;
         `AFD_OFS_UPPER_P1: rdata_d = {3'h0, upper_p1_q[`AFD_THR_HI_MSB:0]};
         `AFD_OFS_LOWER_P0: rdata_d = lower_p0_q;
         `AFD_OFS_LOWER_P1: rdata_d = {3'h0, lower_p1_q[`AFD_THR_HI_MSB:0]};
         `AFD_OFS_DWELL_P0: rdata_d = dwell_p0_q;
         `AFD_OFS_DWELL_P1: rdata_d = dwell_p1_q;
         `AFD_OFS_OVR_CLEAR: rdata_d = ovr_clear_q;
         // Sticky status shows the virtual converters' overrange history.
         `AFD_OFS_OVR_STICKY: rdata_d = sticky;
         `AFD_OFS_FILL_SEL: rdata_d = fill_sel_q;
         default: rdata_d = `AFD_UNMAPPED;
      endcase
   end

   // Read answer, one cycle after the read strobe.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // Magnitudes are taken from the converter output samples.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mag_a_q <= {MAG_W{1'b0}};
         mag_b_q <= {MAG_W{1'b0}};
      end else begin
         mag_a_q <= mag_of(sample_a_i);
         mag_b_q <= mag_of(sample_b_i);
      end
   end

   // Independent detector for channel A; flag two clocks after the sample.
   afd_fd_chan #(
      .MAG_W(MAG_W),
      .DWELL_W(DWELL_W)
   ) u_fd_a (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .mag_i(mag_a_q),
      .upper_i(upper_thr),
      .lower_i(lower_thr),
      .dwell_i(dwell),
      .flag_o(level_flag_chan_a_o)
   );

   // Independent detector for channel B with the shared thresholds.
   afd_fd_chan #(
      .MAG_W(MAG_W),
      .DWELL_W(DWELL_W)
   ) u_fd_b (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .mag_i(mag_b_q),
      .upper_i(upper_thr),
      .lower_i(lower_thr),
      .dwell_i(dwell),
      .flag_o(level_flag_chan_b_o)
   );

   // Sticky overrange status for each virtual converter.
   afd_ovr_sticky #(
      .NVC(NVC)
   ) u_sticky (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .ovr_i(vc_ovr_i),
      .clear_reg_i(ovr_clear_q[NVC-1:0]),
      .sticky_o(sticky)
   );

   // Link stage: samples and overrange bits pass in the same register,
   // so the in-band bit keeps the sample latency.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         link_a_q <= {SMP_W{1'b0}};
         link_b_q <= {SMP_W{1'b0}};
         link_ovr_a_q <= 1'b0;
         link_ovr_b_q <= 1'b0;
         link_k_q <= 1'b0;
         link_run_q <= 1'b0;
         pd_q <= 1'b0;
      end else if (pd_now) begin
         // Power-down halts the link entirely.
         link_a_q <= {SMP_W{1'b0}};
         link_b_q <= {SMP_W{1'b0}};
         link_ovr_a_q <= 1'b0;
         link_ovr_b_q <= 1'b0;
         link_k_q <= 1'b0;
         link_run_q <= 1'b0;
         pd_q <= 1'b1;
      end else if (sb_now) begin
         // Standby keeps the link up and sends zeros or K characters.
         link_a_q <= {SMP_W{1'b0}};
         link_b_q <= {SMP_W{1'b0}};
         link_ovr_a_q <= 1'b0;
         link_ovr_b_q <= 1'b0;
         link_k_q <= fill_sel_q[`AFD_FILL_K_BIT];
         link_run_q <= 1'b1;
         pd_q <= 1'b0;
      end else begin
         // Normal operation forwards samples with the overrange bit.
         link_a_q <= sample_a_i;
         link_b_q <= sample_b_i;
         link_ovr_a_q <= ovr_a_i & ctrl_bits_en_i;
         link_ovr_b_q <= ovr_b_i & ctrl_bits_en_i;
         link_k_q <= 1'b0;
         link_run_q <= 1'b1;
         pd_q <= 1'b0;
      end
   end
endmodule

// ==== tb/afd_checker.sv ====
// Port-level checker for the fast-detect, overrange and power-down block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module afd_checker #(
   parameter SMP_W = 14,
   parameter NVC = 8
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [SMP_W-1:0] sample_a_i,
   input wire [SMP_W-1:0] sample_b_i,
   input wire ovr_a_i,
   input wire ovr_b_i,
   input wire [NVC-1:0] vc_ovr_i,
   input wire ctrl_bits_en_i,
   input wire powerdown_standby_pin_i,
   input wire [11:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire reg_rvalid_o,
   input wire level_flag_chan_a_o,
   input wire level_flag_chan_b_o,
   input wire [SMP_W-1:0] link_sample_a_o,
   input wire [SMP_W-1:0] link_sample_b_o,
   input wire link_ovr_a_o,
   input wire link_ovr_b_o,
   input wire link_is_k_o,
   input wire link_run_o,
   input wire powered_down_o
);
   // True for codes whose magnitude is the full-scale 8191, which no lower threshold can undercut.
   function automatic logic fs(input logic [SMP_W-1:0] s);
      fs = (s == 14'h1FFF) || (s == 14'h2000) || (s == 14'h2001);
   endfunction

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_rd_answer;
      1'b1 |-> reg_rvalid_o == $past(reg_rd_i);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late or missing");
   property p_rise_a;
      $rose(level_flag_chan_a_o) |-> $past(sample_a_i, 2) != 14'h0000;
   endproperty
   a_rise_a: assert property (p_rise_a) else $error("flag a rose without cause");
   property p_rise_b;
      $rose(level_flag_chan_b_o) |-> $past(sample_b_i, 2) != 14'h0000;
   endproperty
   a_rise_b: assert property (p_rise_b) else $error("flag b rose without cause");
   property p_fall_a;
      $fell(level_flag_chan_a_o) |-> !fs($past(sample_a_i, 2));
   endproperty
   a_fall_a: assert property (p_fall_a) else $error("flag a fell at full scale");
   property p_link_a;
      link_sample_a_o != 14'h0000 |-> link_sample_a_o == $past(sample_a_i);
   endproperty
   a_link_a: assert property (p_link_a) else $error("link sample a wrong");
   property p_link_ovr;
      link_ovr_a_o |-> $past(ovr_a_i) && $past(ctrl_bits_en_i);
   endproperty
   a_link_ovr: assert property (p_link_ovr) else $error("in-band overrange wrong");
   property p_pd_halt;
      powered_down_o |-> !link_run_o;
   endproperty
   a_pd_halt: assert property (p_pd_halt) else $error("link runs in power-down");
   property p_fill;
      link_is_k_o |-> link_run_o && link_sample_a_o == 14'h0000 && !link_ovr_a_o;
   endproperty
   a_fill: assert property (p_fill) else $error("standby fill wrong");
   property p_sticky;
      reg_rvalid_o && $past(reg_addr_i) == 12'h563 && !$past(rst_i, 2)
         |-> (reg_rdata_o & $past(vc_ovr_i, 2)) == $past(vc_ovr_i, 2);
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky bit missing");

   c_flag: cover property ($rose(level_flag_chan_a_o));
   c_fill: cover property (link_is_k_o);
   c_pd: cover property (powered_down_o);
endmodule

// ==== tb/afd_rx_model.sv ====
// Receiver-side model: counts link words and control-character fills.
// Assumes it sees the link status on the sample clock.
`timescale 1ns/1ps
module afd_rx_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic link_run_i,
   input wire logic link_is_k_i,
   output logic [31:0] rx_cnt_o,
   output logic [31:0] k_cnt_o
);
   // A word arrives only while the link runs; a halted link delivers nothing.
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rx_cnt_o <= 32'h0;
         k_cnt_o <= 32'h0;
      end else if (link_run_i) begin
         rx_cnt_o <= rx_cnt_o + 32'h1;
         k_cnt_o <= k_cnt_o + {31'h0, link_is_k_i};
      end
   end
endmodule

// ==== tb/afd_top_tb.sv ====
// Self-checking bench for the fast-detect, overrange and power-down block.
// Assumes the receiver model and the bound checker sit beside the design.
`timescale 1ns/1ps
module afd_top_tb;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [13:0] smp_a = 14'h0, smp_b = 14'h0, es[2];
   logic ovr_a = 1'b0, ovr_b = 1'b0, cben = 1'b0, pin = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] vc = 8'h00, wd = 8'h00, eo;
   logic [11:0] ad = 12'h000;
   wire [7:0] rdat;
   wire [13:0] lsa, lsb;
   wire rv, fa, fb, ova, ovb, isk, run, pdn;
   wire [31:0] rx_cnt, k_cnt;
   integer error_cnt = 0, checked = 0;
   logic [31:0] lf = 32'h0001_7D50;
   int upper = 8191, lower = 0, dwell = 1, fl[2], cn[2], mq[2], r0, k0;
   bit mon_fd, mon_lk, pdm, sbm, fk;
   logic [11:0] ra[12] = '{12'h03F, 12'h040, 12'h247, 12'h248, 12'h249, 12'h24A,
                           12'h24B, 12'h24C, 12'h562, 12'h563, 12'h571, 12'h100};
   logic [7:0] rv0[12] = '{8'h00, 8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00,
                           8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int ma[6] = '{0, 3, 0, 0, 2, 0}, mb[6] = '{0, 0, 0, 1, 0, 2};
   int mp[6] = '{0, 0, 1, 1, 0, 1}, mf[6] = '{0, 0, 0, 1, 0, 0};
   int sticky = 0;

   afd_top u_afd_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sample_a_i(smp_a),
      .sample_b_i(smp_b), .ovr_a_i(ovr_a), .ovr_b_i(ovr_b), .vc_ovr_i(vc),
      .ctrl_bits_en_i(cben), .powerdown_standby_pin_i(pin), .reg_addr_i(ad),
      .reg_wdata_i(wd), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdat),
      .reg_rvalid_o(rv), .level_flag_chan_a_o(fa), .level_flag_chan_b_o(fb),
      .link_sample_a_o(lsa), .link_sample_b_o(lsb), .link_ovr_a_o(ova),
      .link_ovr_b_o(ovb), .link_is_k_o(isk), .link_run_o(run), .powered_down_o(pdn));
   afd_rx_model u_afd_rx_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link_run_i(run),
      .link_is_k_i(isk), .rx_cnt_o(rx_cnt), .k_cnt_o(k_cnt));

   always #5 clk_sys_i = ~clk_sys_i;

   function automatic [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Saturating magnitude of a two's complement sample.
   function automatic int mag(input [13:0] s);
      int v;
      v = $signed(s);
      if (v < 0) v = -v;
      mag = (v > 8191) ? 8191 : v;
   endfunction
   task chk(input bit ok, input string m);
      checked++;
      if (!ok) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask
   task wr(input [11:0] a, input [7:0] d);
      @(posedge clk_sys_i);
      ad <= a;
      wd <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
   endtask
   task rd(input [11:0] a, input [7:0] e);
      @(posedge clk_sys_i);
      ad <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      #1 chk(rv === 1'b1 && rdat === e, "read data");
   endtask
   // Mostly small samples so that the dwell count can run out, now and then a large one.
   task stream(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         lf = nxt(lf);
         smp_a <= (lf[2:0] == 3'h0) ? lf[16:3] : {4'h0, lf[12:3]};
         smp_b <= (lf[20:18] == 3'h0) ? lf[31:18] : {4'h0, lf[30:21]};
         ovr_a <= lf[5];
         ovr_b <= lf[9];
         cben <= lf[13];
      end
      @(posedge clk_sys_i);
      smp_a <= 14'h0;
      smp_b <= 14'h0;
      repeat (8) @(posedge clk_sys_i);
   endtask

   // Reference model, updated on the same edge as the design.
   always @(posedge clk_sys_i) begin
      if (!rst_i) begin
         for (int c = 0; c < 2; c++) begin
            if (mq[c] > upper) begin
               fl[c] = 1;
               cn[c] = 0;
            end else if (mq[c] < lower) begin
               cn[c]++;
               if (cn[c] > dwell) fl[c] = 0;
            end else cn[c] = 0;
         end
         mq[0] = mag(smp_a);
         mq[1] = mag(smp_b);
         es[0] = sbm ? 14'h0 : smp_a;
         es[1] = sbm ? 14'h0 : smp_b;
         eo = {6'h0, !sbm && ovr_b && cben, !sbm && ovr_a && cben};
      end
   end
   // Outputs are compared mid-cycle, once settled.
   always @(negedge clk_sys_i) begin
      if (mon_fd) begin
         chk(fa === fl[0], "flag a");
         chk(fb === fl[1], "flag b");
      end
      if (mon_lk) begin
         chk(run === !pdm && pdn === pdm, "power state");
         chk(isk === (sbm && fk), "fill kind");
         if (!pdm) chk(lsa === es[0] && lsb === es[1] && {ovb, ova} === eo[1:0], "link");
      end
   end

   task conclude;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys_i);
      error_cnt++;
      $display("MISMATCH at %0t: run too long", $time);
      conclude;
   end

   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      chk(fa === 1'b0 && fb === 1'b0, "flags after reset");
      for (int i = 0; i < 12; i++) rd(ra[i], rv0[i]);
      wr(12'h563, 8'hFF);
      rd(12'h563, 8'h00);
      $display("test registers done");
      for (int k = 0; k < 2; k++) begin
         upper = 4095;
         lower = 2589;
         dwell = k ? 5 : 1;
         wr(12'h247, 8'hFF);
         wr(12'h248, 8'h0F);
         wr(12'h249, 8'h1D);
         wr(12'h24A, 8'h0A);
         wr(12'h24B, dwell[7:0]);
         wr(12'h24C, 8'h00);
         mon_fd = 1;
         mon_lk = 1;
         stream(1500);
         mon_fd = 0;
         mon_lk = 0;
         $display("test fast detect dwell %0d done", dwell);
      end
      for (int m = 0; m < 6; m++) begin
         pdm = ma[m] == 3 || (mp[m] == 1 && mb[m] == 0);
         sbm = !pdm && (ma[m] == 2 || (mp[m] == 1 && mb[m] == 1));
         fk = mf[m];
         @(posedge clk_sys_i);
         pin <= mp[m][0];
         wr(12'h03F, ma[m][7:0]);
         wr(12'h040, mb[m][7:0]);
         wr(12'h571, {mf[m][0], 7'h00});
         repeat (3) @(posedge clk_sys_i);
         mon_lk = 1;
         r0 = rx_cnt;
         k0 = k_cnt;
         stream(50);
         mon_lk = 0;
         chk((rx_cnt === r0) == pdm, "receiver words");
         chk((k_cnt !== k0) == (sbm && fk), "receiver fills");
         $display("test power mode %0d done", m);
      end
      for (int j = 0; j < 3; j++) begin
         lf = nxt(lf);
         // The overrange stays high through the read, so the checker sees it too.
         @(posedge clk_sys_i);
         vc <= lf[7:0];
         sticky |= lf[7:0];
         rd(12'h563, sticky[7:0]);
         @(posedge clk_sys_i);
         vc <= 8'h00;
         wr(12'h562, lf[15:8]);
         wr(12'h562, 8'h00);
         sticky &= ~lf[15:8];
         rd(12'h563, sticky[7:0]);
      end
      $display("test sticky overrange done");
      conclude;
   end
endmodule

bind afd_top afd_checker #(.SMP_W(SMP_W), .NVC(NVC)) u_afd_checker (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sample_a_i(sample_a_i),
   .sample_b_i(sample_b_i), .ovr_a_i(ovr_a_i), .ovr_b_i(ovr_b_i), .vc_ovr_i(vc_ovr_i),
   .ctrl_bits_en_i(ctrl_bits_en_i), .powerdown_standby_pin_i(powerdown_standby_pin_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .level_flag_chan_a_o(level_flag_chan_a_o), .level_flag_chan_b_o(level_flag_chan_b_o),
   .link_sample_a_o(link_sample_a_o), .link_sample_b_o(link_sample_b_o),
   .link_ovr_a_o(link_ovr_a_o), .link_ovr_b_o(link_ovr_b_o), .link_is_k_o(link_is_k_o),
   .link_run_o(link_run_o), .powered_down_o(powered_down_o));
